// ### bench/tb.sv
// self-checking bench for the timer input-capture block
// assumes zero-wait apb slave and the pin source model
`include "tic_params.svh"
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, s); \
   numErrors++; end end

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wantLevel = 1'b0;
   logic        timerIn;
   logic        timerIrq;
   logic [31:0] q;
   logic        e;
   int          numErrors = 0;
   int          checkCount = 0;
   int          irqN = 0;
   int          n0;

   always #50 clk = ~clk;
   always @(posedge clk) if (timerIrq === 1'b1) irqN <= irqN + 1;

   tic_timer_capture dut (.clk(clk), .sys_rst(sysRst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerIn(timerIn), .timerIrq(timerIrq));
   tic_pin_src src (.clk(clk), .wantLevel(wantLevel), .timerIn(timerIn));

   task automatic completeRun;
      $display("checks %0d errors %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : completeRun

   // one apb transfer: setup, then access held until pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK("prdata", x, q)
      `CHK("pslverr", 1'b0, e)
   endtask : rd

   // high for hi clocks then low for lo clocks
   task automatic pulse(input int hi, input int lo);
      @(posedge clk) wantLevel <= 1'b1;
      repeat (hi) @(posedge clk);
      wantLevel <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask : pulse

   task automatic setup(input logic [31:0] c1, input logic [31:0] rl);
      wr(`TIC_OFF_CTRL1, c1);
      wr(`TIC_OFF_COUNT, 32'h1);
      wr(`TIC_OFF_RELOAD, rl);
      wr(`TIC_OFF_CAPT, 32'h0);
      wr(`TIC_OFF_CTRL1, c1 | 32'h1);
   endtask : setup

   initial begin
      #(100 * 20000);
      numErrors++;
      completeRun();
   end

   initial begin
      repeat (3) @(posedge clk);
      sysRst <= 1'b0;
      rd(`TIC_OFF_CTRL0, 32'h0);
      rd(`TIC_OFF_CTRL1, 32'h0);
      rd(`TIC_OFF_COUNT, 32'h0);
      rd(`TIC_OFF_RELOAD, 32'h0000FFFF);
      rd(`TIC_OFF_CAPT, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped data", 32'h0, q)
      `CHK("unmapped err", 1'b1, e)
      // restart mode, divide by 1, rising edge
      setup(32'h22, 32'hFFFF);
      n0 = irqN;
      pulse(10, 30);
      pulse(10, 30);
      rd(`TIC_OFF_CAPT, 32'd41);
      `CHK("irq rise", n0 + 2, irqN)
      rd(`TIC_OFF_CTRL0, 32'h4);
      wr(`TIC_OFF_CTRL0, 32'h4);
      rd(`TIC_OFF_CTRL0, 32'h0);
      // restart mode, divide by 4, falling edge
      setup(32'h28, 32'hFFFF);
      n0 = irqN;
      pulse(10, 30);
      pulse(10, 30);
      rd(`TIC_OFF_CAPT, 32'd11);
      `CHK("irq fall", n0 + 2, irqN)
      // reload-only source hides capture interrupts
      wr(`TIC_OFF_CTRL0, 32'h2);
      n0 = irqN;
      pulse(10, 30);
      `CHK("irq masked", n0, irqN)
      rd(`TIC_OFF_CTRL0, 32'h6);
      // capture mode, divide by 2, reloads; capture-only source hides them
      wr(`TIC_OFF_CTRL0, 32'h7);
      setup(32'h04, 32'd20);
      n0 = irqN;
      repeat (60) @(posedge clk);
      `CHK("irq reload masked", n0, irqN)
      wr(`TIC_OFF_CTRL0, 32'h0);
      n0 = irqN;
      repeat (100) @(posedge clk);
      `CHK("reload irq", 1'b1, (irqN - n0) >= 2)
      rd(`TIC_OFF_CAPT, 32'h0);
      rd(`TIC_OFF_CTRL0, 32'h0);
      // a capture in capture mode sets the flag and keeps counting
      pulse(10, 30);
      rd(`TIC_OFF_CTRL0, 32'h4);
      apb(1'b0, `TIC_OFF_CAPT, 32'h0);
      `CHK("capture mode", 1'b1, q[15:0] != 16'h0)
      // disabled timer ignores the pin
      wr(`TIC_OFF_CTRL1, 32'h02);
      wr(`TIC_OFF_CAPT, 32'h0);
      n0 = irqN;
      pulse(10, 30);
      rd(`TIC_OFF_CAPT, 32'h0);
      `CHK("irq off", n0, irqN)
      completeRun();
   end
endmodule : tb

// ### bench/tic_pin_src.sv
// far-side signal source that drives the timer input pin
// assumes the bench holds each requested level for at least two clocks
module tic_pin_src (
   // system
   input  wire logic clk,
   // requested pin level
   input  wire logic wantLevel,
   // timer input pin
   output logic      timerIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // the pin changes one clock after the request, unrelated to the counter
   always_ff @(posedge clk) begin
      timerIn <= wantLevel;
   end
endmodule : tic_pin_src

// ### core/tic_params.svh
// constants of the timer input-capture block: offsets, fields, reset values
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
// Notes on behaviour
// RULE_01: in capture-restart mode a selected input edge copies the count into the capture register.
// RULE_02: in capture-restart mode the count advances from the prescaled system clock, the pin only triggers.
// RULE_03: the edge polarity bit picks whether a rising or a falling input edge captures.
// RULE_04: a capture in capture-restart mode raises the timer interrupt, loads 0001H and counting goes on.
// RULE_05: an interrupt caused by a capture sets the input capture flag in the first control register.
// RULE_06: after reset both capture and reload interrupt; the source select can restrict to either one.
// RULE_07: software writes the control register with the timer off, choosing mode, prescale and edge.
// RULE_08: software loads the start count, usually 0001H, before enabling the timer.
// RULE_09: software writes the reload value while the timer is still disabled.
// RULE_10: software clears capture to 0000H first; still 0000H after an interrupt means a reload.
// RULE_11: software sets interrupt enables and pin routing before it enables the timer.
// RULE_12: the count steps once per prescale system clock periods.
// RULE_13: in capture mode the count runs to the reload value, then interrupts and restarts.
// RULE_14: the capture register holds the full 16-bit captured count.
// RULE_15: the input is synchronised and edge-detected, and nothing is captured while disabled.
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH
`define TIC_OFF_CTRL0     8'h00
`define TIC_OFF_CTRL1     8'h04
`define TIC_OFF_COUNT     8'h08
`define TIC_OFF_RELOAD    8'h0C
`define TIC_OFF_CAPT      8'h10
`define TIC_CTRL0_SEL     1:0
`define TIC_CTRL0_FLAG    2
`define TIC_CTRL1_EN      0
`define TIC_CTRL1_POL     1
`define TIC_CTRL1_PRE     4:2
`define TIC_CTRL1_MODE    5
`define TIC_SEL_BOTH      2'h0
`define TIC_SEL_RELOAD    2'h2
`define TIC_SEL_CAPT      2'h3
`define TIC_COUNT_RESTART 16'h0001
`define TIC_COUNT_RST     16'h0000
`define TIC_RELOAD_RST    16'hFFFF
`define TIC_CAPT_CLEAR    16'h0000
`endif

// ### core/tic_pkg.sv
// types of the timer input-capture block
// assumes tic_params.svh supplies the numeric constants
package tic_pkg;
   typedef enum logic [1:0] {
      TIC_IDLE = 2'b00,
      TIC_RUN  = 2'b01
   } tic_state_t;

   typedef enum logic {
      TIC_MODE_CAPTURE = 1'b0,
      TIC_MODE_RESTART = 1'b1
   } tic_mode_t;

   typedef struct packed {
      logic       en;
      logic       polRise;
      logic [2:0] pre;
      tic_mode_t  mode;
   } tic_cfg_t;
endpackage : tic_pkg

// ### core/tic_timer_capture.sv
// timer with input capture and capture-restart modes behind an apb slave
// assumes clk is the system clock and timerIn is an asynchronous pin
//
// Decided for this implementation: the APB register port and the placing of the registers.
`include "tic_params.svh"

module tic_timer_capture #(
   parameter int CNT_W = 16
) (
   // system
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // timer input pin
   input  wire logic        timerIn,
   // timer interrupt request
   output logic             timerIrq
);
   generate
      if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
         $error("CNT_W must lie between 2 and 16");
      end
   endgenerate

   localparam logic [CNT_W-1:0] RESTART = CNT_W'(`TIC_COUNT_RESTART);

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `TIC_OFF_CTRL0) || (a == `TIC_OFF_CTRL1) ||
               (a == `TIC_OFF_COUNT) || (a == `TIC_OFF_RELOAD) ||
               (a == `TIC_OFF_CAPT);
   endfunction : mapped

   function automatic logic [6:0] preLimit(input logic [2:0] p);
      preLimit = 7'((8'h01 << p) - 8'h01);
   endfunction : preLimit

   tic_pkg::tic_cfg_t   cfg_r, cfg_nxt;
   tic_pkg::tic_state_t state_r, state_nxt;
   logic [1:0]          irqSel_r, irqSel_nxt;
   logic                capFlag_r, capFlag_nxt;
   logic [CNT_W-1:0]    count_r, count_nxt;
   logic [CNT_W-1:0]    reload_r, reload_nxt;
   logic [CNT_W-1:0]    capt_r, capt_nxt;
   logic [6:0]          preCnt_r, preCnt_nxt;
   logic                inSync1_r, inSync2_r, inPrev_r;
   logic                irq_r, irq_nxt;
   logic [31:0]         prdata_r, prdata_nxt;
   logic                setup, access, wr, running, tick;
   logic                edgeSeen, capEvt, relEvt;

   assign pready   = 1'b1;
   assign pslverr  = access & ~mapped(paddr);
   assign prdata   = prdata_r;
   assign timerIrq = irq_r;

   always_comb begin
      setup    = psel & ~penable;
      access   = psel & penable;
      wr       = access & pwrite & mapped(paddr);
      running  = (state_r == tic_pkg::TIC_RUN);
      tick     = running && (preCnt_r == preLimit(cfg_r.pre)); // RULE_12
      // selected edge from synchronised samples only
      edgeSeen = cfg_r.polRise ? (inSync2_r & ~inPrev_r)
                               : (~inSync2_r & inPrev_r); // RULE_03
      capEvt   = running & edgeSeen; // RULE_15
      relEvt   = tick && (count_r == reload_r);

      cfg_nxt     = cfg_r;
      irqSel_nxt  = irqSel_r;
      capFlag_nxt = capFlag_r;
      count_nxt   = count_r;
      reload_nxt  = reload_r;
      capt_nxt    = capt_r;
      prdata_nxt  = prdata_r;

      // software writes
      if (wr) begin
         case (paddr)
            `TIC_OFF_CTRL0: begin
               irqSel_nxt = pwdata[`TIC_CTRL0_SEL];
               if (pwdata[`TIC_CTRL0_FLAG]) begin
                  capFlag_nxt = 1'b0;
               end
            end
            `TIC_OFF_CTRL1: begin
               cfg_nxt.en      = pwdata[`TIC_CTRL1_EN];
               cfg_nxt.polRise = pwdata[`TIC_CTRL1_POL];
               cfg_nxt.pre     = pwdata[`TIC_CTRL1_PRE];
               cfg_nxt.mode    = tic_pkg::tic_mode_t'(pwdata[`TIC_CTRL1_MODE]);
            end
            `TIC_OFF_COUNT:  count_nxt  = pwdata[CNT_W-1:0];
            `TIC_OFF_RELOAD: reload_nxt = pwdata[CNT_W-1:0];
            `TIC_OFF_CAPT:   capt_nxt   = pwdata[CNT_W-1:0];
            default: ;
         endcase
      end

      // prescaler and counting
      preCnt_nxt = running ? (tick ? 7'h00 : 7'(preCnt_r + 7'h01)) : 7'h00;
      if (tick) begin
         count_nxt = relEvt ? RESTART : CNT_W'(count_r + 1'b1); // RULE_02 RULE_13
      end

      // capture, hardware wins over a software write
      if (capEvt) begin
         capt_nxt    = count_r; // RULE_01 RULE_14
         capFlag_nxt = 1'b1; // RULE_05
         if (cfg_r.mode == tic_pkg::TIC_MODE_RESTART) begin
            count_nxt  = RESTART; // RULE_04
            preCnt_nxt = 7'h00;
         end
      end

      // interrupt source select
      irq_nxt = (capEvt && irqSel_r != `TIC_SEL_RELOAD) ||
                (relEvt && irqSel_r != `TIC_SEL_CAPT); // RULE_06

      state_nxt = cfg_nxt.en ? tic_pkg::TIC_RUN : tic_pkg::TIC_IDLE;

      // read data captured in the setup phase
      if (setup && !pwrite) begin
         case (paddr)
            `TIC_OFF_CTRL0:  prdata_nxt = {29'h0, capFlag_r, irqSel_r};
            `TIC_OFF_CTRL1:  prdata_nxt = {26'h0, cfg_r.mode, cfg_r.pre,
                                           cfg_r.polRise, cfg_r.en};
            `TIC_OFF_COUNT:  prdata_nxt = 32'(count_r);
            `TIC_OFF_RELOAD: prdata_nxt = 32'(reload_r);
            `TIC_OFF_CAPT:   prdata_nxt = 32'(capt_r); // RULE_10
            default:         prdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_r     <= '0;
         state_r   <= tic_pkg::TIC_IDLE;
         irqSel_r  <= `TIC_SEL_BOTH;
         capFlag_r <= 1'b0;
         count_r   <= CNT_W'(`TIC_COUNT_RST);
         reload_r  <= CNT_W'(`TIC_RELOAD_RST);
         capt_r    <= CNT_W'(`TIC_CAPT_CLEAR);
         preCnt_r  <= 7'h00;
         inSync1_r <= 1'b0;
         inSync2_r <= 1'b0;
         inPrev_r  <= 1'b0;
         irq_r     <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         cfg_r     <= cfg_nxt;
         state_r   <= state_nxt;
         irqSel_r  <= irqSel_nxt;
         capFlag_r <= capFlag_nxt;
         count_r   <= count_nxt;
         reload_r  <= reload_nxt;
         capt_r    <= capt_nxt;
         preCnt_r  <= preCnt_nxt;
         inSync1_r <= timerIn; // RULE_15
         inSync2_r <= inSync1_r;
         inPrev_r  <= inSync2_r;
         irq_r     <= irq_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_cap_latch: assert property ( // RULE_01
      capEvt && !(wr && paddr == `TIC_OFF_CAPT) |=> capt_r == $past(count_r))
      else $error("capture did not latch the count");
   a_pin_indep: assert property ( // RULE_02
      tick && !capEvt && !relEvt && !(wr && paddr == `TIC_OFF_COUNT)
      |=> count_r == CNT_W'($past(count_r) + 1'b1))
      else $error("count did not step on a prescaler tick");
   a_edge_pol: assert property ( // RULE_03
      running && $rose(inSync2_r) |-> capEvt == cfg_r.polRise)
      else $error("capture edge polarity wrong");
   a_restart_load: assert property ( // RULE_04
      capEvt && cfg_r.mode == tic_pkg::TIC_MODE_RESTART
      && irqSel_r == `TIC_SEL_BOTH |=> count_r == RESTART && timerIrq)
      else $error("restart did not load one and interrupt");
   a_flag_set: assert property ( // RULE_05
      capEvt |=> capFlag_r ##1 (capFlag_r || $past(wr)))
      else $error("input capture flag not set");
   a_irq_select: assert property ( // RULE_06
      capEvt && !relEvt && irqSel_r == `TIC_SEL_RELOAD |=> !timerIrq)
      else $error("capture interrupt not masked by source select");
   a_capt_keep: assert property ( // RULE_10
      !capEvt && !(wr && paddr == `TIC_OFF_CAPT) |=> $stable(capt_r))
      else $error("capture register changed without capture");
   a_tick_rate: assert property ( // RULE_12
      tick && cfg_r.pre == 3'h1 && !capEvt && !wr
      |=> !tick ##1 (tick || !running || cfg_r.pre != 3'h1 || $past(wr)
                     || $past(capEvt)))
      else $error("prescale by two not kept");
   a_reload_wrap: assert property ( // RULE_13
      relEvt && !capEvt |=> count_r == RESTART)
      else $error("reload did not restart the count");
   a_capture_keeps: assert property ( // RULE_13
      capEvt && cfg_r.mode == tic_pkg::TIC_MODE_CAPTURE && !relEvt
      && !(wr && paddr == `TIC_OFF_COUNT)
      |=> count_r == CNT_W'($past(count_r) + $past(tick)))
      else $error("capture mode disturbed the count");
   a_off_quiet: assert property ( // RULE_15
      !running |-> !capEvt && !tick)
      else $error("activity while disabled");

   c_capture:  cover property (capEvt && cfg_r.mode == tic_pkg::TIC_MODE_CAPTURE);
   c_restart:  cover property (capEvt && cfg_r.mode == tic_pkg::TIC_MODE_RESTART);
   c_reload:   cover property (relEvt ##1 timerIrq);
   c_flag_clr: cover property (capFlag_r ##1 !capFlag_r);
   c_half_rate: cover property (tick && cfg_r.pre == 3'h1);
endmodule : tic_timer_capture
